// File: logic/flash_host.sv
/*
  host controller for a byte-wide block-erasable flash: turns orders written
  over APB into one- or two-cycle command writes and read cycles on the
  flash's asynchronous pins.
  assumes the flash pins are wired directly; data pins are split into
  in, out and enable; the elevated reset level is an external switch.
*/
// Operation
// RL1 - low program supply still allows reads only
// RL2 - ready_busy_n low while device algorithm runs
// RL3 - device starts in read array mode
// RL4 - FFH write selects read array mode
// RL5 - read array ignored during unsuspended operation
// RL6 - read array accepted at any supply
// RL7 - 90H then reads return identifier codes
// RL8 - 70H then reads return status
// RL9 - erase is 20H then D0H in block
// RL10 - program setup 40H or 10H, then byte
// RL11 - address and data captured at strobe rise
// RL12 - B0H requests suspend
// RL13 - D0H resumes suspended operation
// RL14 - locked block needs elevated reset level
// RL15 - block lock is 60H then 01H
// RL16 - master lock is 60H then F1H, elevated
// RL17 - 60H then D0H clears all block locks
// RL18 - host writes only defined command codes
// RL19 - 50H clears status error flags
// RL20 - reset pin low returns read array mode
// RL21 - write uses select and write strobe only
// RL22 - read uses select and output enable only
// RL23 - after two-cycle commands reads give status
// RL24 - deselect floats data outputs
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_host
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // flash pins
  output logic      [20:0] flash_addr_o,
  input  wire logic [7:0]  flash_dq_i,
  output logic      [7:0]  flash_dq_o,
  output logic             flash_dq_oe_o,
  output logic             chip_select_n_o,
  output logic             output_enable_n_o,
  output logic             write_enable_n_o,
  output logic             reset_powerdown_n_o,
  output logic             elevated_reset_level_o,
  output logic             program_enable_o,
  input  wire logic        ready_busy_n_i
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [20:0] addr_reg, next_addr_reg;
  logic [7:0]  wdata_reg, next_wdata_reg;
  logic [7:0]  rdata_reg, next_rdata_reg;
  logic [2:0]  pins_reg, next_pins_reg;
  logic        refused, next_refused;
  op_e         op, next_op;
  seq_e        seq, next_seq;
  logic        second, next_second;   // second bus cycle pending
  logic [3:0]  cnt, next_cnt;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready;
  logic        pslverr, next_pslverr;
  logic [7:0]  dq_out, next_dq_out;
  logic        dq_oe, next_dq_oe;
  logic        cs_n, next_cs_n;
  logic        oe_n, next_oe_n;
  logic        we_n, next_we_n;
  logic [2:0]  rb_sync;                 // pin synchroniser
  logic        rb_state, next_rb_state;
  logic [7:0]  dq_s1, dq_s2, dq_s3;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // three stages each; for ready/busy the second and third must agree
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rb_sync <= 3'h7;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
      dq_s3   <= 8'h00;
    end else begin
      rb_sync <= {rb_sync[1:0], ready_busy_n_i};
      dq_s1   <= flash_dq_i;
      dq_s2   <= dq_s1;
      dq_s3   <= dq_s2;
    end
  end

  // ready/busy level follows agreed samples
  always_comb begin
    next_rb_state = rb_state;
    if (rb_sync[1] == rb_sync[2]) begin
      next_rb_state = rb_sync[2]; // RL2
    end
  end

  // ----------------------------------------------------------------------
  // first and second bus cycle data per operation
  // ----------------------------------------------------------------------
  function automatic logic [7:0] first_code(input op_e o);
    case (o)
      OP_READ_ARRAY:   first_code = `CMD_READ_ARRAY;  // RL4 RL6
      OP_READ_ID:      first_code = `CMD_READ_ID;     // RL7
      OP_READ_STATUS:  first_code = `CMD_READ_STATUS; // RL8
      OP_CLEAR_STATUS: first_code = `CMD_CLEAR_STATUS; // RL19
      OP_ERASE:        first_code = `CMD_ERASE_SETUP; // RL9
      OP_PROGRAM:      first_code = `CMD_PROGRAM;     // RL10
      OP_SUSPEND:      first_code = `CMD_SUSPEND;     // RL12
      OP_RESUME:       first_code = `CMD_CONFIRM;     // RL13
      default:         first_code = `CMD_LOCK_SETUP;  // RL15 RL16 RL17
    endcase
  endfunction

  function automatic logic [7:0] second_code(input op_e o, input logic [7:0] d);
    case (o)
      OP_ERASE:       second_code = `CMD_CONFIRM;     // RL9
      OP_PROGRAM:     second_code = d;                // RL10
      OP_LOCK_BLOCK:  second_code = `CMD_LOCK_BLOCK;  // RL15
      OP_LOCK_MASTER: second_code = `CMD_LOCK_MASTER; // RL16
      default:        second_code = `CMD_CONFIRM;     // RL17
    endcase
  endfunction

  function automatic logic two_cycle(input op_e o);
    two_cycle = (o == OP_ERASE) || (o == OP_PROGRAM) || (o == OP_LOCK_BLOCK) ||
                (o == OP_LOCK_MASTER) || (o == OP_UNLOCK_ALL);
  endfunction

  // ----------------------------------------------------------------------
  // apb slave and bus sequencer
  // ----------------------------------------------------------------------
  logic acc;
  logic go_req;
  op_e  req_op;
  logic alters;

  always_comb begin
    acc    = psel_i && penable_i && !pready;
    req_op = op_e'(pwdata_i[`CMD_KIND_LSB +: 4]);
    go_req = acc && pwrite_i && (paddr_i == `REG_CMD) && pwdata_i[`CMD_GO_BIT];
    // altering orders need supply; only master lock also needs the elevated level
    alters = two_cycle(req_op);
    next_addr_reg  = addr_reg;
    next_wdata_reg = wdata_reg;
    next_rdata_reg = rdata_reg;
    next_pins_reg  = pins_reg;
    next_refused   = refused;
    next_op        = op;
    next_seq       = seq;
    next_second    = second;
    next_cnt       = cnt;
    next_prdata    = prdata;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_dq_out    = dq_out;
    next_dq_oe     = dq_oe;
    next_cs_n      = cs_n;
    next_oe_n      = oe_n;
    next_we_n      = we_n;
    // register access answers one cycle into the access phase
    if (acc) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      if (pwrite_i) begin
        case (paddr_i)
          `REG_ADDR:   next_addr_reg  = pwdata_i[20:0];
          `REG_WDATA:  next_wdata_reg = pwdata_i[7:0];
          `REG_PINS:   next_pins_reg  = pwdata_i[2:0];
          `REG_CMD: begin
            if (seq != ST_IDLE) begin
              next_pslverr = 1'b1;
            end
          end
          `REG_STATUS: next_refused = refused & ~pwdata_i[`ST_REFUSED_BIT];
          default:     next_pslverr = 1'b1;
        endcase
      end else begin
        case (paddr_i)
          `REG_ADDR:   next_prdata = {11'h000, addr_reg};
          `REG_WDATA:  next_prdata = {24'h000000, wdata_reg};
          `REG_CMD:    next_prdata = {28'h0000000, op};
          `REG_STATUS: next_prdata = {29'h00000000, refused, rb_state, seq != ST_IDLE};
          `REG_RDATA:  next_prdata = {24'h000000, rdata_reg};
          `REG_PINS:   next_prdata = {29'h00000000, pins_reg};
          default:     next_pslverr = 1'b1;
        endcase
      end
    end
    case (seq)
      ST_IDLE: begin
        if (go_req) begin
          // low supply: refuse any altering order at the host
          if (alters && !pins_reg[`PIN_VPP_BIT]) begin
            next_refused = 1'b1;                                 // RL1
          end else if (!pins_reg[`PIN_RESET_BIT]) begin
            next_refused = 1'b1;                                 // RL20
          end else if (req_op > OP_READ) begin
            next_refused = 1'b1;                                 // RL18
          end else if (req_op == OP_LOCK_MASTER && !pins_reg[`PIN_ELEV_BIT]) begin
            next_refused = 1'b1;                                 // RL16
          end else begin
            next_op     = req_op;
            next_second = two_cycle(req_op);
            next_seq    = ST_SETUP;
            next_cnt    = 4'h0;
          end
        end
      end
      ST_SETUP: begin
        next_cs_n = 1'b0;
        if (op == OP_READ) begin
          next_oe_n  = 1'b0;                                     // RL22
          next_dq_oe = 1'b0;                                     // RL24
        end else begin
          next_oe_n   = 1'b1;                                    // RL21
          next_we_n   = 1'b0;
          next_dq_oe  = 1'b1;
          next_dq_out = first_code(op);
        end
        next_seq = ST_STROBE;
      end
      ST_STROBE: begin
        next_cnt = cnt + 4'h1;
        if (op == OP_READ) begin
          if (cnt == 4'(`ACCESS_CYC)) begin
            next_rdata_reg = dq_s3;                              // RL7 RL8 RL23
            next_oe_n      = 1'b1;
            next_cs_n      = 1'b1;
            next_seq       = ST_RECOVER;
            next_cnt       = 4'h0;
          end
        end else if (cnt == 4'(`STROBE_CYC)) begin
          // write strobe rises first, select after: data held across
          next_we_n = 1'b1;                                      // RL11
          next_seq  = ST_RECOVER;
          next_cnt  = 4'h0;
        end
      end
      ST_RECOVER: begin
        next_cnt  = cnt + 4'h1;
        next_cs_n = 1'b1;
        if (cnt == 4'(`RECOVER_CYC)) begin
          next_dq_oe = 1'b0;                                     // RL24
          if (second) begin
            next_second = 1'b0;
            next_dq_out = second_code(op, wdata_reg);            // RL10 RL9
            next_cs_n   = 1'b0;
            next_we_n   = 1'b0;
            next_dq_oe  = 1'b1;
            next_seq    = ST_STROBE;
            next_cnt    = 4'h0;
          end else begin
            next_seq = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_seq = ST_IDLE;
      end
      default: next_seq = ST_IDLE;
    endcase
  end

  // register all state except the pin synchronisers
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      addr_reg  <= 21'h000000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      pins_reg  <= `RESET_VALUE_PINS;   // RL3
      refused   <= 1'b0;
      op        <= OP_READ_ARRAY;
      seq       <= ST_IDLE;
      second    <= 1'b0;
      cnt       <= 4'h0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      dq_out    <= 8'h00;
      dq_oe     <= 1'b0;
      cs_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
      rb_state  <= 1'b1;
    end else begin
      addr_reg  <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      rdata_reg <= next_rdata_reg;
      pins_reg  <= next_pins_reg;
      refused   <= next_refused | (go_req && seq != ST_IDLE);
      op        <= next_op;
      seq       <= next_seq;
      second    <= next_second;
      cnt       <= next_cnt;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      dq_out    <= next_dq_out;
      dq_oe     <= next_dq_oe;
      cs_n      <= next_cs_n;
      oe_n      <= next_oe_n;
      we_n      <= next_we_n;
      rb_state  <= next_rb_state;
    end
  end

  // ----------------------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------------------
  assign prdata_o               = prdata;
  assign pready_o               = pready;
  assign pslverr_o              = pslverr;
  assign flash_addr_o           = addr_reg;
  assign flash_dq_o             = dq_out;
  assign flash_dq_oe_o          = dq_oe;
  assign chip_select_n_o        = cs_n;
  assign output_enable_n_o      = oe_n;
  assign write_enable_n_o       = we_n;
  assign reset_powerdown_n_o    = pins_reg[`PIN_RESET_BIT];  // RL20
  assign elevated_reset_level_o = pins_reg[`PIN_ELEV_BIT];   // RL14
  assign program_enable_o       = pins_reg[`PIN_VPP_BIT];    // RL1

endmodule

// File: logic/flash_host_defs.svh
/*
  command codes, bus cycle timing counts and register offsets for the
  flash command host. assumes a 40 MHz clock and an APB register port.
*/
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_READ_ARRAY    8'hFF
`define CMD_READ_ID       8'h90
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_ERASE_SETUP   8'h20
`define CMD_CONFIRM       8'hD0
`define CMD_PROGRAM       8'h40
`define CMD_PROGRAM_ALT   8'h10
`define CMD_SUSPEND       8'hB0
`define CMD_LOCK_SETUP    8'h60
`define CMD_LOCK_BLOCK    8'h01
`define CMD_LOCK_MASTER   8'hF1

// ----------------------------------------------------------------------
// bus cycle timing (ns figures and derived cycle counts at 25 ns)
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define T_STROBE_NS       100
`define T_ACCESS_NS       150
`define T_RECOVER_NS      50
`define STROBE_CYC        ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC        ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC       ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------------
`define REG_ADDR          12'h000
`define REG_WDATA         12'h004
`define REG_CMD           12'h008
`define REG_STATUS        12'h00C
`define REG_RDATA         12'h010
`define REG_PINS          12'h014
`define CMD_KIND_LSB      0
`define CMD_GO_BIT        4
`define ST_BUSY_BIT       0
`define ST_RDY_BIT        1
`define ST_REFUSED_BIT    2
`define PIN_RESET_BIT     0
`define PIN_ELEV_BIT      1
`define PIN_VPP_BIT       2
`define RESET_VALUE_PINS  3'h1

`endif

// File: logic/flash_host_pkg.sv
/*
  types for the flash command host.
  assumes flash_host_defs.svh for numeric constants.
*/
package flash_host_pkg;

  // ----------------------------------------------------------------------
  // operation kinds software may order
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_READ_ID, OP_READ_STATUS, OP_CLEAR_STATUS,
    OP_ERASE, OP_PROGRAM, OP_SUSPEND, OP_RESUME,
    OP_LOCK_BLOCK, OP_LOCK_MASTER, OP_UNLOCK_ALL, OP_READ
  } op_e;

  // ----------------------------------------------------------------------
  // bus sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_DONE
  } seq_e;

endpackage

// File: tb/flash_host_properties.sv
/*
  pin and apb answer checks for flash_host.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module flash_host_props (
  // clock, reset and apb
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // flash pins
  input wire logic [20:0] flash_addr_o,
  input wire logic [7:0]  flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic        chip_select_n_o,
  input wire logic        output_enable_n_o,
  input wire logic        write_enable_n_o,
  input wire logic        reset_powerdown_n_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------------
  // strobe shapes and apb answers
  // ----------------------------------------------------------------------
  sequence s_we_low; (!write_enable_n_o) [*5] ##1 write_enable_n_o; endsequence
  sequence s_cs_late; !chip_select_n_o ##1 chip_select_n_o; endsequence
  property p_answer; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  property p_pulse; pready_o |=> !pready_o; endproperty
  property p_err; pslverr_o |-> pready_o; endproperty
  property p_write;
    !write_enable_n_o |-> !chip_select_n_o && output_enable_n_o && flash_dq_oe_o;
  endproperty
  property p_read;
    !output_enable_n_o |-> !chip_select_n_o && write_enable_n_o && !flash_dq_oe_o;
  endproperty
  property p_we_len; $fell(write_enable_n_o) |-> s_we_low; endproperty
  property p_latch; $rose(write_enable_n_o) |-> s_cs_late; endproperty
  property p_hold;
    !write_enable_n_o && !$past(write_enable_n_o) |-> $stable(flash_dq_o) && $stable(flash_addr_o);
  endproperty
  property p_oe_len;
    $fell(output_enable_n_o) |-> (!output_enable_n_o) [*7] ##1 output_enable_n_o;
  endproperty
  property p_rp; !reset_powerdown_n_o |-> chip_select_n_o; endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_write: assert property (p_write) else $error("write strobe misqualified");
  a_read: assert property (p_read) else $error("read strobe misqualified");
  a_we_len: assert property (p_we_len) else $error("write strobe length wrong");
  a_latch: assert property (p_latch) else $error("chip select rose early");
  a_hold: assert property (p_hold) else $error("data moved under strobe");
  a_oe_len: assert property (p_oe_len) else $error("read strobe length wrong");
  a_rp: assert property (p_rp) else $error("access in powerdown");
endmodule

// File: tb/flash_device_model.sv
/*
  behavioural flash device for the host bench.
  assumes strobes, address and data come straight from the host.
*/
`timescale 1ns/1ps
module flash_device_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'h5E, // arbitrary value
  parameter int         BUSY_NS  = 2000
) (
  // flash pins
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rp_n_i,
  input  wire logic        elev_i,
  input  wire logic        vpp_i,
  input  wire logic [20:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o,
  output logic             dq_oe_o,
  output logic             ready_busy_n_o,
  // command history seen on the pins
  output logic      [7:0]  code1_o,
  output logic      [7:0]  code2_o,
  output logic      [20:0] addr1_o,
  output logic      [20:0] addr2_o,
  output int               writes_o
);
  logic [7:0]  mem [256];
  logic [31:0] lock;
  logic        master, busy, susp;
  logic [1:0]  mode;
  logic [7:0]  setup, sr;
  int          left;
  wire  [4:0]  blk     = addr_i[20:16];
  wire         ok_lock = !master || elev_i;
  // power-up state: erased, unlocked, array reads
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {lock, master, busy, susp, mode, setup, sr, writes_o} = '0;
  end
  // powerdown aborts and returns to array reads
  always @(negedge rp_n_i) {busy, susp, mode, setup, sr} = '0;
  // algorithm timer, frozen while suspended
  always #25 if (busy && !susp) begin
    left = left - 25;
    if (left <= 0) busy = 1'b0;
  end
  task automatic run(input logic ok, input logic [7:0] err);
    if (ok) {busy, left} = {1'b1, BUSY_NS};
    else sr = sr | err;
  endtask
  // command taken at the first rising strobe
  always @(posedge we_n_i or posedge cs_n_i) if ((!cs_n_i || !we_n_i) && rp_n_i) begin
    {code1_o, addr1_o, code2_o, addr2_o} = {code2_o, addr2_o, dq_i, addr_i};
    writes_o = writes_o + 1;
    if (setup != 8'h00) begin
      mode = 2'h2;
      case (setup)
        8'h20: run(dq_i == 8'hD0 && vpp_i && (!lock[blk] || elev_i), 8'h22);
        8'h60: case (dq_i)
          8'h01: if (ok_lock && vpp_i) lock[blk] = 1'b1; else sr = sr | 8'h12;
          8'hF1: if (elev_i && vpp_i) master = 1'b1; else sr = sr | 8'h12;
          8'hD0: if (ok_lock && vpp_i) lock = '0; else sr = sr | 8'h22;
          default: sr = sr | 8'h30;
        endcase
        default: begin
          run(vpp_i && (!lock[blk] || elev_i), 8'h12);
          if (busy) mem[addr_i[7:0]] = dq_i;
        end
      endcase
      setup = 8'h00;
    end else if (busy && !susp) begin
      if (dq_i == 8'hB0) susp = 1'b1;
    end else case (dq_i)
      8'hFF: mode = 2'h0;
      8'h90: mode = 2'h1;
      8'h70: mode = 2'h2;
      8'h50: sr = 8'h00;
      8'hD0: susp = 1'b0;
      8'h20, 8'h40, 8'h10, 8'h60: setup = dq_i;
      default: ;
    endcase
  end
  // outputs float unless selected and enabled
  assign dq_oe_o = !cs_n_i && !oe_n_i && rp_n_i;
  assign ready_busy_n_o = !(busy && !susp);
  always_comb case (mode)
    2'h0: dq_o = mem[addr_i[7:0]];
    2'h1: dq_o = (addr_i[1:0] == 2'h0) ? MAKER_ID : (addr_i[1:0] == 2'h1) ? PART_ID :
                 {7'h00, addr_i[0] ? master : lock[blk]};
    default: dq_o = {ready_busy_n_o, sr[6:0]};
  endcase
endmodule

// File: tb/flash_host_test.sv
/*
  bench for flash_host: apb orders in, device model on the pins.
  assumes flash_host_defs.svh and the device model.
*/
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host_test import flash_host_pkg::*; ;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  logic        clock_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic        pready_o, pslverr_o, dq_oe, cs_n, oe_n, we_n, rp_n, elev, vpp, rb_n, dev_oe;
  logic [20:0] faddr, a1, a2;
  logic [7:0]  dq_o, dev_dq, c1, c2, dq_last = '0;
  int          fail_count = 0, total_checks = 0, writes;
  // released bus shows a changing pattern
  wire  [7:0]  dq_w = dq_oe ? dq_o : dev_oe ? dev_dq : ~dq_last;
  always @(posedge clock_i) dq_last <= dq_w;
  initial forever #12.5 clock_i = ~clock_i;
  flash_host dut (.clock_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .flash_addr_o(faddr), .flash_dq_i(dq_w),
    .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe), .chip_select_n_o(cs_n),
    .output_enable_n_o(oe_n), .write_enable_n_o(we_n), .reset_powerdown_n_o(rp_n),
    .elevated_reset_level_o(elev), .program_enable_o(vpp), .ready_busy_n_i(rb_n));
  flash_device_model #(.MAKER_ID(MAKER)) dev (.cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .rp_n_i(rp_n), .elev_i(elev), .vpp_i(vpp), .addr_i(faddr), .dq_i(dq_w), .dq_o(dev_dq),
    .dq_oe_o(dev_oe), .ready_busy_n_o(rb_n), .code1_o(c1), .code2_o(c2), .addr1_o(a1),
    .addr2_o(a2), .writes_o(writes));
  // ----------------------------------------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung wait
    do @(posedge clock_i); while (pready_o !== 1'b1);
    {r, e} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic order(input op_e op);
    logic [31:0] s;
    wr(`REG_CMD, 32'h10 | op);
    do rd(`REG_STATUS, s); while (s[0] !== 1'b0);
  endtask
  task automatic wait_ready;
    logic [31:0] s;
    do rd(`REG_STATUS, s); while (s[1] !== 1'b1);
  endtask
  task automatic read_byte(input logic [7:0] exp);
    logic [31:0] r;
    order(OP_READ);
    rd(`REG_RDATA, r);
    chk(r, {24'h0, exp});
  endtask
  task automatic bit_is(input int b, input logic v);
    logic [31:0] s;
    rd(`REG_STATUS, s);
    chk(s[b], v);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_boot;
    logic [31:0] r;
    logic        e;
    rd(`REG_PINS, r);
    chk(r, 32'h1);
    bit_is(`ST_BUSY_BIT, 1'b0);
    wr(`REG_ADDR, 32'h3);
    read_byte(8'hFF);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(e, 1'b1);
    // reserved op code is refused without pin activity
    wr(`REG_CMD, 32'h1F);
    bit_is(`ST_REFUSED_BIT, 1'b1);
    wr(`REG_STATUS, 32'h4);
    // a second order while the sequencer runs is answered with an error
    wr(`REG_CMD, 32'h1B);
    apb(1'b1, `REG_CMD, 32'h1B, r, e);
    chk(e, 1'b1);
    do rd(`REG_STATUS, r); while (r[0] !== 1'b0);
    wr(`REG_STATUS, 32'h4);
    $display("test boot done");
  endtask
  task automatic t_cmds; // only defined codes are ordered
    op_e         ops [11] = '{OP_READ_ID, OP_READ_STATUS, OP_CLEAR_STATUS, OP_READ_ARRAY,
      OP_ERASE, OP_PROGRAM, OP_LOCK_BLOCK, OP_UNLOCK_ALL, OP_LOCK_MASTER, OP_SUSPEND, OP_RESUME};
    logic [15:0] code [11] = '{16'h0090, 16'h0070, 16'h0050, 16'h00FF, 16'h20D0, 16'h403C,
      16'h6001, 16'h60D0, 16'h60F1, 16'h00B0, 16'h00D0};
    wr(`REG_PINS, 32'h7);
    wr(`REG_ADDR, 32'h010005);
    wr(`REG_WDATA, 32'h3C);
    foreach (ops[i]) begin
      order(ops[i]);
      wait_ready;
      chk(c2, code[i][7:0]);
      if (code[i][15:8] != 8'h00) begin
        chk(c1, code[i][15:8]);
        chk({a1, a2}, {21'h010005, 21'h010005});
      end
    end
    $display("test commands done");
  endtask
  task automatic t_program;
    wr(`REG_PINS, 32'h5);
    wr(`REG_ADDR, 32'h7);
    wr(`REG_WDATA, 32'h5A);
    order(OP_PROGRAM);
    bit_is(`ST_RDY_BIT, 1'b0);
    order(OP_SUSPEND);
    bit_is(`ST_RDY_BIT, 1'b1);
    order(OP_RESUME);
    bit_is(`ST_RDY_BIT, 1'b0);
    order(OP_READ_ARRAY);
    read_byte(8'h00);
    wait_ready;
    read_byte(8'h80);
    order(OP_READ_ARRAY);
    read_byte(8'h5A);
    $display("test program done");
  endtask
  task automatic t_lock;
    int n;
    wr(`REG_PINS, 32'h7);
    wr(`REG_ADDR, 32'h9);
    order(OP_LOCK_BLOCK);
    wr(`REG_PINS, 32'h5);
    order(OP_PROGRAM);
    wait_ready;
    read_byte(8'h92);
    order(OP_CLEAR_STATUS);
    read_byte(8'h80);
    order(OP_READ_ID);
    wr(`REG_ADDR, 32'h2);
    read_byte(8'h01);
    wr(`REG_ADDR, 32'h0);
    read_byte(MAKER);
    wr(`REG_PINS, 32'h1);
    n = writes;
    order(OP_ERASE);
    bit_is(`ST_REFUSED_BIT, 1'b1);
    chk(writes, n);
    wr(`REG_STATUS, 32'h4);
    order(OP_READ_ARRAY);
    read_byte(8'hFF);
    $display("test lock done");
  endtask
  task automatic t_rp;
    order(OP_READ_STATUS);
    wr(`REG_PINS, 32'h0);
    order(OP_READ_ARRAY);
    bit_is(`ST_REFUSED_BIT, 1'b1);
    wr(`REG_PINS, 32'h1);
    wr(`REG_STATUS, 32'h4);
    wr(`REG_ADDR, 32'h7);
    read_byte(8'h5A);
    $display("test powerdown done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence after a two cycle reset
  initial begin
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_boot;
    t_cmds;
    t_program;
    t_lock;
    t_rp;
    end_sim;
  end
  // watchdog
  initial begin
    #1000000;
    fail_count++;
    end_sim;
  end
endmodule
bind flash_host flash_host_props chk (.clock_i, .rst_b_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .chip_select_n_o,
  .output_enable_n_o, .write_enable_n_o, .reset_powerdown_n_o);
